//--- logic/frl_defines.svh
// Purpose: Constants for the fault reconfiguration logic
// Assumes: 100 MHz system clock
// Notes: Times in ns, counts derived
`ifndef FRL_DEFINES_SVH
`define FRL_DEFINES_SVH
`define FRL_CLK_NS 10
`define FRL_RECOV_MIN_NS 32000
`define FRL_TRANS_MIN_NS 16000
`define FRL_UNIT_CYC ((`FRL_TRANS_MIN_NS) / (`FRL_CLK_NS))
`define FRL_RECONF_CYC 4
`define FRL_DATA_W 32
`define FRL_CODE_W 39
`define FRL_MEM_DEPTH 16
`define FRL_BS_PRIM 0
`define FRL_BS_BACK 1
`define FRL_BS_BKAVL 2
`define FRL_BS_REDUN 3
`define FRL_ET_BUS 2'h0
`define FRL_ET_MOD 2'h1
`define FRL_ET_BUSMOD 2'h2
`endif

//--- logic/frl_pkg.sv
// Purpose: Types for the fault reconfiguration logic
// Assumes: frl_defines.svh included
// Notes: Carrier structs plus the one-hot state enum
`include "frl_defines.svh"
package frl_pkg;
   typedef struct packed
   {
      logic valid;
      logic permanent;
      logic [1:0] err_type;
      logic [1:0] bus_id;
      logic [5:0] module_id;
   } frl_report_t;
   typedef struct packed
   {
      logic req;
      logic wr;
      logic [3:0] addr;
      logic [31:0] wdata;
   } frl_mem_req_t;
   typedef enum logic [3:0]
   {
      FRL_IDLE = 4'b0001,
      FRL_WAIT = 4'b0010,
      FRL_RECONF = 4'b0100,
      FRL_DONE = 4'b1000
   } frl_state_t;
endpackage

//--- logic/frl_node.sv
// Purpose: Per-node recovery after a permanent error, plus memory array recovery
// Assumes: Error log report arrives from the detection logic, same clock
// Notes: One node can act as bus interface node or memory controller node
// Functional notes
// - Each node reconfigures alone; activate backup else lock damaged memory.
// - Reconfiguration completes within first few cycles of quiescent period.
// - Node decides from its four-way setting and its bus state redundancy bit whether it is redundant.
// - Clear married flag when report module matches spouse and flag set.
// - Unmarried survivor takes every access instead of alternating.
// - Matching backup bus, range enabled, interleave or redundancy sets both ranges.
// - Memory node on reported bus with backup available toggles bus select.
// - Without redundancy, lock memory left inconsistent by partial multi-module write.
// - Transient errors raise no message; logs only.
// - Permanent error raises reconfiguration message to local processors only.
// - Normal mode forwards read data before ECC check completes.
// - Staged mode returns corrected data, no report for correctable errors.
// - Check code corrects single-bit and detects double-bit errors.
// - Refresh reads one location, reports error, writes back corrected data.
// - Software-controlled spare bit substitutes for any one bit position.
// - Node failing to deactivate is isolated via its other confinement area.
// - Quiescent period length set by timeout duration register.
// - Minimum setting gives about 32 us recovery, 16 us transient limit.
`timescale 1ns/10ps
module frl_node
   import frl_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RESET_I,
   // Configuration
   input wire logic IS_MEM_NODE_I,
   input wire logic [1:0] OWN_BUS_ID_I,
   input wire logic [1:0] BACKUP_BUS_ID_I,
   input wire logic [5:0] SPOUSE_ID_I,
   input wire logic MARRIED_SET_I,
   input wire logic FOUR_WAY_I,
   input wire logic [3:0] BUS_STATE_INIT_I,
   input wire logic INIT_I,
   input wire logic [7:0] TIMEOUT_DURATION_I,
   input wire logic SPARE_EN_I,
   input wire logic [5:0] SPARE_POS_I,
   // Error report log
   input wire frl_report_t REPORT_I,
   input wire logic MMA_PARTIAL_I,
   input wire logic OTHER_AREA_DEAD_I,
   // Memory access and refresh
   input wire frl_mem_req_t MEM_REQ_I,
   input wire logic REFRESH_I,
   input wire logic ACCESS_TURN_I,
   // Status and outputs
   output logic MARRIED_O,
   output logic ACTIVE_ACCESS_O,
   output logic [3:0] BUS_STATE_O,
   output logic BUS_SELECT_LINE_O,
   output logic MEM_LOCKED_O,
   output logic INTERPROCESSOR_MESSAGE_O,
   output logic QUIESCENT_O,
   output logic STAGED_O,
   output logic NODE_ISOLATED_O,
   output logic [31:0] RDATA_O,
   output logic RDATA_VALID_O,
   output logic ECC_CORR_O,
   output logic ECC_UNCORR_O,
   output logic SCRUB_REPORT_O
);
   localparam int unsigned UNIT_CYC = `FRL_UNIT_CYC;

   frl_state_t state_r;
   logic [22:0] quiet_cnt_r;
   logic [7:0] step_r;
   logic [2:0] reconf_cnt_r;
   logic [1:0] rep_bus_r;
   logic [5:0] rep_mod_r;
   logic [1:0] rep_type_r;
   logic mma_r;
   logic [38:0] mem_r [`FRL_MEM_DEPTH];
   logic [3:0] scrub_addr_r;
   logic fwd_pend_r;
   logic [31:0] fwd_fix_r;
   logic fwd_bad_r;
   logic fwd_corr_r;

   // Hamming check bits over 38 bit positions, plus overall parity
   function automatic logic [38:0] ecc_enc(input logic [31:0] d);
      logic [38:0] w;
      int k;
      w = '0;
      k = 0;
      for (int p = 1; p < 39; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            w[p] = d[k];
            k++;
         end
      end
      for (int b = 0; b < 6; b++)
      begin
         for (int p = 1; p < 39; p++)
         begin
            if ((p & (1 << b)) != 0 && p != (1 << b))
            begin
               w[1 << b] = w[1 << b] ^ w[p];
            end
         end
      end
      w[0] = ^w[38:1];
      return w;
   endfunction

   function automatic logic [31:0] ecc_data(input logic [38:0] w);
      logic [31:0] d;
      int k;
      d = '0;
      k = 0;
      for (int p = 1; p < 39; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            d[k] = w[p];
            k++;
         end
      end
      return d;
   endfunction

   // Returns {uncorrectable, corrected, fixed word}
   function automatic logic [40:0] ecc_fix(input logic [38:0] w);
      logic [5:0] syn;
      logic par;
      logic [38:0] f;
      syn = '0;
      f = w;
      for (int p = 1; p < 39; p++)
      begin
         if (w[p])
         begin
            syn = syn ^ p[5:0];
         end
      end
      par = ^w;
      if (syn == 6'h00 && !par)
      begin
         return {2'b00, w};
      end
      if (par)
      begin
         if (syn < 6'd39)
         begin
            f[syn] = ~f[syn];
         end
         return {2'b01, f};
      end
      return {2'b10, w};
   endfunction

   // Spare bit stands in for the chosen position on reads
   function automatic logic [38:0] spare_sub(input logic [38:0] w, input logic s,
      input logic en, input logic [5:0] pos);
      logic [38:0] r;
      r = w;
      if (en && pos < 6'd39)
      begin
         r[pos] = s;
      end
      return r;
   endfunction

   logic [15:0] spare_r;
   logic [40:0] rd_fix;
   logic [40:0] sc_fix;
   logic [38:0] rd_word;
   logic [38:0] sc_word;
   logic [38:0] wr_word;
   logic rep_perm;
   logic redundant_bus;
   logic bus_match;
   logic mod_match;

   assign rep_perm = REPORT_I.valid && REPORT_I.permanent;
   assign rd_word = spare_sub(mem_r[MEM_REQ_I.addr], spare_r[MEM_REQ_I.addr],
      SPARE_EN_I, SPARE_POS_I);
   assign sc_word = spare_sub(mem_r[scrub_addr_r], spare_r[scrub_addr_r], SPARE_EN_I,
      SPARE_POS_I);
   assign rd_fix = ecc_fix(rd_word);
   assign sc_fix = ecc_fix(sc_word);
   assign wr_word = ecc_enc(MEM_REQ_I.wdata);
   assign redundant_bus = FOUR_WAY_I || BUS_STATE_O[`FRL_BS_REDUN];
   assign bus_match = rep_type_r != `FRL_ET_MOD;
   assign mod_match = rep_type_r != `FRL_ET_BUS;

   // Quiescent sequence timed by the timeout duration setting
   always_ff @(posedge CLOCK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         state_r <= FRL_IDLE;
         quiet_cnt_r <= '0;
         step_r <= '0;
         reconf_cnt_r <= '0;
         rep_bus_r <= '0;
         rep_mod_r <= '0;
         rep_type_r <= '0;
         mma_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            FRL_IDLE:
            begin
               if (rep_perm)
               begin
                  state_r <= FRL_RECONF;
                  rep_bus_r <= REPORT_I.bus_id;
                  rep_mod_r <= REPORT_I.module_id;
                  rep_type_r <= REPORT_I.err_type;
                  mma_r <= MMA_PARTIAL_I;
                  reconf_cnt_r <= '0;
               end
            end
            FRL_RECONF:
            begin
               reconf_cnt_r <= reconf_cnt_r + 3'd1;
               if (reconf_cnt_r == 3'(`FRL_RECONF_CYC - 1))
               begin
                  state_r <= FRL_WAIT;
                  quiet_cnt_r <= '0;
                  step_r <= '0;
               end
            end
            FRL_WAIT:
            begin
               if (quiet_cnt_r == 23'(UNIT_CYC - 1))
               begin
                  quiet_cnt_r <= '0;
                  step_r <= step_r + 8'd1;
                  if (step_r >= TIMEOUT_DURATION_I + 8'd1)
                  begin
                     state_r <= FRL_DONE;
                  end
               end
               else
               begin
                  quiet_cnt_r <= quiet_cnt_r + 23'd1;
               end
            end
            FRL_DONE:
            begin
               state_r <= FRL_IDLE;
            end
            default:
            begin
               state_r <= FRL_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         QUIESCENT_O <= 1'b0;
         STAGED_O <= 1'b0;
      end
      else
      begin
         QUIESCENT_O <= state_r == FRL_RECONF || state_r == FRL_WAIT;
         STAGED_O <= IS_MEM_NODE_I && (state_r == FRL_RECONF || state_r == FRL_WAIT);
      end
   end

   // Module and bus reconfiguration in the first quiescent cycle
   always_ff @(posedge CLOCK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         MARRIED_O <= 1'b0;
         BUS_STATE_O <= 4'h0;
         BUS_SELECT_LINE_O <= 1'b0;
         MEM_LOCKED_O <= 1'b0;
         NODE_ISOLATED_O <= 1'b0;
      end
      else if (INIT_I)
      begin
         MARRIED_O <= MARRIED_SET_I;
         BUS_STATE_O <= BUS_STATE_INIT_I;
         BUS_SELECT_LINE_O <= 1'b0;
         MEM_LOCKED_O <= 1'b0;
         NODE_ISOLATED_O <= 1'b0;
      end
      else if (state_r == FRL_RECONF && reconf_cnt_r == 3'd0)
      begin
         if (mod_match && rep_mod_r == SPOUSE_ID_I && MARRIED_O)
         begin
            MARRIED_O <= 1'b0;
         end
         if (!IS_MEM_NODE_I && bus_match && rep_bus_r == BACKUP_BUS_ID_I
             && (BUS_STATE_O[`FRL_BS_PRIM] || BUS_STATE_O[`FRL_BS_BACK])
             && redundant_bus)
         begin
            BUS_STATE_O[`FRL_BS_PRIM] <= 1'b1;
            BUS_STATE_O[`FRL_BS_BACK] <= 1'b1;
         end
         if (IS_MEM_NODE_I && bus_match && rep_bus_r == OWN_BUS_ID_I
             && BUS_STATE_O[`FRL_BS_BKAVL])
         begin
            BUS_SELECT_LINE_O <= ~BUS_SELECT_LINE_O;
            BUS_STATE_O[`FRL_BS_BKAVL] <= 1'b0;
         end
         if (mma_r && !MARRIED_O && !redundant_bus)
         begin
            MEM_LOCKED_O <= 1'b1;
         end
         if (OTHER_AREA_DEAD_I && bus_match && mod_match)
         begin
            NODE_ISOLATED_O <= 1'b1;
            BUS_STATE_O[`FRL_BS_PRIM] <= 1'b0;
            BUS_STATE_O[`FRL_BS_BACK] <= 1'b0;
         end
      end
   end

   // Message to local processors only, never onto the memory bus
   always_ff @(posedge CLOCK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         INTERPROCESSOR_MESSAGE_O <= 1'b0;
         ACTIVE_ACCESS_O <= 1'b0;
      end
      else
      begin
         INTERPROCESSOR_MESSAGE_O <= !IS_MEM_NODE_I && state_r == FRL_IDLE && rep_perm;
         ACTIVE_ACCESS_O <= !MARRIED_O || ACCESS_TURN_I;
      end
   end

   // Memory array with spare bit and refresh scrubbing
   always_ff @(posedge CLOCK_I)
   begin
      if (MEM_REQ_I.req && MEM_REQ_I.wr && !MEM_LOCKED_O)
      begin
         mem_r[MEM_REQ_I.addr] <= wr_word;
         spare_r[MEM_REQ_I.addr] <= (SPARE_POS_I < 6'd39) ? wr_word[SPARE_POS_I] : 1'b0;
      end
      else if (REFRESH_I && sc_fix[39])
      begin
         mem_r[scrub_addr_r] <= sc_fix[38:0];
         spare_r[scrub_addr_r] <= (SPARE_POS_I < 6'd39) ? sc_fix[SPARE_POS_I] : 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         scrub_addr_r <= '0;
         SCRUB_REPORT_O <= 1'b0;
      end
      else
      begin
         SCRUB_REPORT_O <= REFRESH_I && (sc_fix[39] || sc_fix[40]);
         if (REFRESH_I)
         begin
            scrub_addr_r <= scrub_addr_r + 4'd1;
         end
      end
   end

   // Read path: forward early in normal mode, corrected in staged mode
   always_ff @(posedge CLOCK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         RDATA_O <= '0;
         RDATA_VALID_O <= 1'b0;
         ECC_CORR_O <= 1'b0;
         ECC_UNCORR_O <= 1'b0;
         fwd_fix_r <= '0;
         fwd_bad_r <= 1'b0;
         fwd_corr_r <= 1'b0;
         fwd_pend_r <= 1'b0;
      end
      else
      begin
         RDATA_VALID_O <= 1'b0;
         fwd_pend_r <= 1'b0;
         ECC_CORR_O <= fwd_pend_r && fwd_corr_r;
         ECC_UNCORR_O <= fwd_pend_r && fwd_bad_r;
         if (MEM_REQ_I.req && !MEM_REQ_I.wr && !MEM_LOCKED_O)
         begin
            RDATA_VALID_O <= 1'b1;
            if (STAGED_O)
            begin
               RDATA_O <= ecc_data(rd_fix[38:0]);
               fwd_corr_r <= 1'b0;
            end
            else
            begin
               RDATA_O <= ecc_data(rd_word);
               fwd_corr_r <= rd_fix[39];
            end
            fwd_bad_r <= rd_fix[40];
            fwd_pend_r <= 1'b1;
         end
      end
   end
endmodule

//--- verif/frl_node_asserts.sv
// Purpose: Port assertions for the recovery node
// Assumes: One clock domain, reset active high
// Notes: Bound into every frl_node
`timescale 1ns/10ps
module frl_node_asserts
   import frl_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RESET_I,
   // Watched inputs
   input wire logic IS_MEM_NODE_I,
   input wire logic [1:0] OWN_BUS_ID_I,
   input wire logic [1:0] BACKUP_BUS_ID_I,
   input wire logic [5:0] SPOUSE_ID_I,
   input wire logic FOUR_WAY_I,
   input wire logic INIT_I,
   input wire frl_report_t REPORT_I,
   input wire frl_mem_req_t MEM_REQ_I,
   // Watched outputs
   input wire logic MARRIED_O,
   input wire logic ACTIVE_ACCESS_O,
   input wire logic [3:0] BUS_STATE_O,
   input wire logic BUS_SELECT_LINE_O,
   input wire logic MEM_LOCKED_O,
   input wire logic INTERPROCESSOR_MESSAGE_O,
   input wire logic QUIESCENT_O,
   input wire logic STAGED_O,
   input wire logic RDATA_VALID_O,
   input wire logic ECC_CORR_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);
   logic take;
   assign take = REPORT_I.valid && REPORT_I.permanent && !QUIESCENT_O && !INIT_I;
   msg_on_perm_a:
      assert property (take && !IS_MEM_NODE_I |=> INTERPROCESSOR_MESSAGE_O)
      else $error("no message after permanent report");
   quiet_stage_a:
      assert property (take |=> ##1 QUIESCENT_O && STAGED_O == IS_MEM_NODE_I)
      else $error("no quiescent staged period");
   transient_a:
      assert property (REPORT_I.valid && !REPORT_I.permanent |=> !INTERPROCESSOR_MESSAGE_O)
      else $error("message on transient");
   mem_silent_a:
      assert property (IS_MEM_NODE_I && $past(IS_MEM_NODE_I) |-> !INTERPROCESSOR_MESSAGE_O)
      else $error("memory node raised message");
   spouse_clear_a:
      assert property (take && REPORT_I.err_type != 2'h0 && REPORT_I.module_id == SPOUSE_ID_I
         && MARRIED_O |=> ##1 !MARRIED_O)
      else $error("married flag not cleared");
   survivor_a:
      assert property ($fell(MARRIED_O) |=> ACTIVE_ACCESS_O [*4])
      else $error("survivor not on every access");
   ranges_a:
      assert property (take && !IS_MEM_NODE_I && REPORT_I.err_type != 2'h1
         && REPORT_I.bus_id == BACKUP_BUS_ID_I
         && |BUS_STATE_O[1:0] && (FOUR_WAY_I || BUS_STATE_O[3]) |=> ##1 &BUS_STATE_O[1:0])
      else $error("ranges not both enabled");
   bus_sel_a:
      assert property (take && IS_MEM_NODE_I && REPORT_I.err_type != 2'h1
         && REPORT_I.bus_id == OWN_BUS_ID_I
         && BUS_STATE_O[2] |=> ##1 BUS_SELECT_LINE_O != $past(BUS_SELECT_LINE_O, 2))
      else $error("bus select not toggled");
   staged_corr_a:
      assert property (STAGED_O && $past(STAGED_O, 2) |-> !ECC_CORR_O)
      else $error("correctable report in staged mode");
   lock_block_a:
      assert property (MEM_LOCKED_O && MEM_REQ_I.req |=> !RDATA_VALID_O)
      else $error("locked memory answered");
   read_fast_a:
      assert property (IS_MEM_NODE_I && MEM_REQ_I.req && !MEM_REQ_I.wr && !MEM_LOCKED_O
         && !STAGED_O |=> RDATA_VALID_O)
      else $error("read data late");
endmodule
bind frl_node frl_node_asserts u_chk
(
   .CLOCK_I(CLOCK_I),
   .RESET_I(RESET_I),
   .IS_MEM_NODE_I(IS_MEM_NODE_I),
   .OWN_BUS_ID_I(OWN_BUS_ID_I),
   .BACKUP_BUS_ID_I(BACKUP_BUS_ID_I),
   .SPOUSE_ID_I(SPOUSE_ID_I),
   .FOUR_WAY_I(FOUR_WAY_I),
   .INIT_I(INIT_I),
   .REPORT_I(REPORT_I),
   .MEM_REQ_I(MEM_REQ_I),
   .MARRIED_O(MARRIED_O),
   .ACTIVE_ACCESS_O(ACTIVE_ACCESS_O),
   .BUS_STATE_O(BUS_STATE_O),
   .BUS_SELECT_LINE_O(BUS_SELECT_LINE_O),
   .MEM_LOCKED_O(MEM_LOCKED_O),
   .INTERPROCESSOR_MESSAGE_O(INTERPROCESSOR_MESSAGE_O),
   .QUIESCENT_O(QUIESCENT_O),
   .STAGED_O(STAGED_O),
   .RDATA_VALID_O(RDATA_VALID_O),
   .ECC_CORR_O(ECC_CORR_O)
);

//--- verif/frl_partner.sv
// Purpose: Processor side reaction to reconfiguration messages
// Assumes: Message is a one-cycle pulse
// Notes: Data processor suspends, interface processor interrupts its host
`timescale 1ns/10ps
module frl_partner
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Message from node
   input wire logic msg_i,
   // Reactions
   output logic suspended_o,
   output logic host_irq_o
);
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         suspended_o <= 1'h0;
         host_irq_o <= 1'h0;
      end
      else
      begin
         suspended_o <= suspended_o | msg_i;
         host_irq_o <= msg_i;
      end
   end
endmodule

//--- verif/testbench.sv
// Purpose: Self-checking bench for the recovery node
// Assumes: Shortest timeout setting, except a setting of 1 in t_lock
// Notes: Spare bit and refresh driven in t_bus_select_line, isolation input in t_lock
`timescale 1ns/10ps
module testbench;
   import frl_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic mem, fway, init, marr, multi_module_access, turn, o_mar, o_act, o_sel, o_lock, o_msg, o_q, o_st;
   logic o_rv, susp, irq, spen, dead, refr, o_cor, o_unc, o_iso, o_scr;
   logic [5:0] spos;
   logic [7:0] tmo;
   int q_run = 0;
   int q_last = 0;
   logic [3:0] bst, o_bs;
   logic [1:0] own, bkp;
   logic [5:0] sp;
   logic [31:0] o_rd;
   frl_report_t rep;
   frl_mem_req_t req;
   int n_errors = 0;
   int n_compared = 0;
   always #5 clk = ~clk;
   frl_node DUT
   (
      .CLOCK_I(clk), .RESET_I(rst), .IS_MEM_NODE_I(mem), .OWN_BUS_ID_I(own),
      .BACKUP_BUS_ID_I(bkp), .SPOUSE_ID_I(sp), .MARRIED_SET_I(marr), .FOUR_WAY_I(fway),
      .BUS_STATE_INIT_I(bst), .INIT_I(init), .TIMEOUT_DURATION_I(tmo),
      .SPARE_EN_I(spen), .SPARE_POS_I(spos), .REPORT_I(rep), .MMA_PARTIAL_I(multi_module_access),
      .OTHER_AREA_DEAD_I(dead), .MEM_REQ_I(req), .REFRESH_I(refr), .ACCESS_TURN_I(turn),
      .MARRIED_O(o_mar), .ACTIVE_ACCESS_O(o_act), .BUS_STATE_O(o_bs),
      .BUS_SELECT_LINE_O(o_sel), .MEM_LOCKED_O(o_lock), .INTERPROCESSOR_MESSAGE_O(o_msg),
      .QUIESCENT_O(o_q), .STAGED_O(o_st), .NODE_ISOLATED_O(o_iso), .RDATA_O(o_rd),
      .RDATA_VALID_O(o_rv), .ECC_CORR_O(o_cor), .ECC_UNCORR_O(o_unc),
      .SCRUB_REPORT_O(o_scr)
   );
   // Length of the last quiescent period in cycles
   always @(posedge clk)
   begin
      if (o_q)
         q_run <= q_run + 1;
      else if (q_run != 0)
      begin
         q_last <= q_run;
         q_run <= 0;
      end
   end
   frl_partner u_host (.clk_i(clk), .rst_i(rst), .msg_i(o_msg), .suspended_o(susp),
      .host_irq_o(irq));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmpb(input logic got, input logic exp);
      cmp({31'h0, got}, {31'h0, exp});
   endtask
   task automatic cfg(input logic m, input logic mr, input logic [3:0] b);
      @(posedge clk);
      mem <= m;
      marr <= mr;
      bst <= b;
      init <= 1'h1;
      @(posedge clk);
      init <= 1'h0;
      @(posedge clk);
   endtask
   task automatic fire(input logic p, input logic [1:0] t, input logic [1:0] b,
      input logic [5:0] m);
      @(posedge clk);
      rep <= '{1'h1, p, t, b, m};
      @(posedge clk);
      rep <= '0;
      #1;
   endtask
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{1'h1, w, a, d};
      @(posedge clk);
      req <= '0;
      #1;
   endtask
   task automatic settle;
      for (int i = 0; i < 6000 && o_q; i++)
      begin
         @(posedge clk);
         #1;
      end
      cmpb(o_q, 1'h0);
      @(posedge clk);
      #1;
      cmp(q_last, (32'(tmo) + 32'd2) * 32'd1600 + 32'd4);
   endtask
   task automatic t_spouse;
      cfg(1'h0, 1'h1, 4'h1);
      turn <= 1'h0;
      fire(1'h1, 2'h1, 2'h3, 6'h05);
      cmpb(o_msg, 1'h1);
      @(posedge clk);
      #1;
      cmpb(o_mar, 1'h0);
      cmpb(susp, 1'h1);
      cmpb(irq, 1'h1);
      @(posedge clk);
      #1;
      cmpb(o_act, 1'h1);
      settle;
      cmpb(q_last >= 3100 && q_last <= 3300, 1'h1);
   endtask
   task automatic t_transient;
      cfg(1'h0, 1'h1, 4'h1);
      fire(1'h0, 2'h1, 2'h3, 6'h05);
      cmpb(o_msg, 1'h0);
      @(posedge clk);
      #1;
      cmpb(o_mar, 1'h1);
      cmpb(o_q, 1'h0);
   endtask
   task automatic t_ranges;
      for (int k = 0; k < 2; k++)
      begin
         cfg(1'h0, 1'h0, 4'h1);
         fway <= k[0];
         fire(1'h1, 2'h0, 2'h2, 6'h3F);
         @(posedge clk);
         #1;
         cmpb(o_bs[1], k[0]);
         settle;
      end
      fway <= 1'h0;
   endtask
   task automatic t_bus_select_line;
      cfg(1'h1, 1'h0, 4'h5);
      spen <= 1'h1;
      spos <= 6'h01;
      acc(1'h1, 4'h0, 32'hFFFF_FFFF);
      // Spare now stands for data bit 0 with a captured zero: a single-bit error
      spos <= 6'h03;
      fire(1'h1, 2'h0, 2'h1, 6'h3F);
      cmpb(o_msg, 1'h0);
      @(posedge clk);
      #1;
      cmpb(o_st, 1'h1);
      cmpb(o_sel, 1'h1);
      acc(1'h0, 4'h0, 32'h0000_0000);
      cmp(o_rd, 32'hFFFF_FFFF);
      @(posedge clk);
      #1;
      cmpb(o_cor, 1'h0);
      settle;
      acc(1'h0, 4'h0, 32'h0000_0000);
      cmpb(o_rv, 1'h1);
      cmp(o_rd, 32'hFFFF_FFFE);
      @(posedge clk);
      #1;
      cmpb(o_cor, 1'h1);
      cmpb(o_unc, 1'h0);
      @(posedge clk);
      refr <= 1'h1;
      @(posedge clk);
      refr <= 1'h0;
      #1;
      cmpb(o_scr, 1'h1);
      acc(1'h0, 4'h0, 32'h0000_0000);
      cmp(o_rd, 32'hFFFF_FFFF);
      spen <= 1'h0;
   endtask
   task automatic t_lock;
      tmo <= 8'h01;
      cfg(1'h1, 1'h0, 4'h3);
      acc(1'h1, 4'h5, 32'h1234_5678);
      multi_module_access <= 1'h1;
      dead <= 1'h1;
      fire(1'h1, 2'h2, 2'h3, 6'h3F);
      @(posedge clk);
      #1;
      multi_module_access <= 1'h0;
      dead <= 1'h0;
      cmpb(o_lock, 1'h1);
      cmpb(o_iso, 1'h1);
      cmp({28'h0, o_bs}, 32'h0000_0000);
      acc(1'h0, 4'h5, 32'h0000_0000);
      cmpb(o_rv, 1'h0);
      settle;
      cfg(1'h1, 1'h0, 4'h0);
      cmpb(o_lock, 1'h0);
      cmpb(o_iso, 1'h0);
   endtask
   task automatic tally_and_finish;
      $display("Compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      {mem, fway, init, marr, multi_module_access, turn} = 6'h00;
      {spen, dead, refr} = 3'h0;
      spos = 6'h00;
      tmo = 8'h00;
      bst = 4'h0;
      own = 2'h1;
      bkp = 2'h2;
      sp = 6'h05;
      rep = '0;
      req = '0;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      t_spouse;
      t_transient;
      t_ranges;
      t_bus_select_line;
      t_lock;
      tally_and_finish;
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      n_errors++;
      tally_and_finish;
   end
endmodule
